// File: hdl/eepec_pkg.sv
// shared constants, register layouts and types of the eeprom program/erase control
// Notes on behaviour
// - protect bits clear only in first 64 cycles or in special modes
// - outside special modes and after the first 64 cycles, set protect bits hold until next reset
// - setup-cell protect bit blocks its program/erase
// - four region bits guard 32/64/128/288 bytes
// - 512-byte array sits atop selected 4K page
// - plain writes never change the setup cell
// - latch and voltage together first: set neither
// - array writes ignored while voltage is on
// - no captured address means no operation
// - latch clear: array reads like rom
// - protection never affects array reads
// - program ignores byte and row bits
// - program only clears bits, erase sets them
// - any row address picks row, any picks bulk
// - bulk erase at setup cell erases all
// - byte bit wins, else row or bulk
// - erase bit read/write at any time
// - latch bit read/write, array writes captured
// - voltage bit writable only while latched
// - control bit 5 always reads zero
// - setup-cell page field picks array base outside single-chip and bootstrap modes (page F there)
// - setup-cell present bit maps array in outside single-chip mode (always mapped there)
// - new setup-cell value acts after reset
package eepec_pkg;

  // register addresses on the cpu bus
  localparam logic [15:0] ADDR_BLOCK_PROTECT   = 16'h1035;
  localparam logic [15:0] ADDR_PROGRAM_CONTROL = 16'h103B;
  localparam logic [15:0] ADDR_SETUP_CELL      = 16'h103F;

  // array geometry
  localparam int          ARRAY_BYTES   = 512;
  localparam int          ROW_BYTES     = 16;
  localparam logic [8:0]  ROW_MASK      = 9'h00F;
  localparam logic [3:0]  TOP_PAGE      = 4'hF;
  localparam logic [2:0]  ARRAY_IN_PAGE = 3'h7;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

  // protection region limits (exclusive end index)
  localparam logic [8:0]  REGION0_END = 9'h020;
  localparam logic [8:0]  REGION1_END = 9'h060;
  localparam logic [8:0]  REGION2_END = 9'h0E0;

  // protect register reset value and clearing window
  localparam logic [4:0]  BLOCK_PROTECT_RESET = 5'h1F;
  localparam logic [6:0]  UNLOCK_CYCLES       = 7'h40;

  // active setup value before the first load after reset
  localparam logic [7:0]  SETUP_RESET = 8'hFF;

  // cpu bus request
  typedef struct packed {
    logic [15:0] addr;   // byte address
    logic [7:0]  wdata;  // write data
    logic        wr;     // write strobe
    logic        rd;     // read strobe
  } eepec_bus_req_type;

  // block protect register layout
  typedef struct packed {
    logic       setup_cell_protect;   // guards the setup cell
    logic [3:0] array_region_protect; // guards the four regions
  } eepec_protect_type;

  // program control register layout
  typedef struct packed {
    logic odd_rows;             // test only
    logic even_rows;            // test only
    logic unused;               // always zero
    logic byte_sel;             // one-byte erase
    logic row_sel;              // row erase
    logic erase;                // erase mode
    logic write_capture_enable; // latch address and data
    logic high_voltage_on;      // pump voltage
  } eepec_program_control_type;

  // setup cell layout
  typedef struct packed {
    logic [3:0] array_base_page; // upper address nibble
    logic       reserved3;       // other option
    logic       watchdog_off;    // other option
    logic       reserved1;       // other option
    logic       array_present;   // array mapped in
  } eepec_setup_type;

  // cell operation kinds
  typedef enum logic [1:0] {
    OP_PROGRAM,
    OP_ERASE_BYTE,
    OP_ERASE_ROW,
    OP_ERASE_BULK
  } eepec_op_kind_type;

  // one cell operation
  typedef struct packed {
    eepec_op_kind_type kind;    // what to do
    logic              to_cell; // aimed at setup cell
    logic [8:0]        index;   // array byte index
    logic [7:0]        data;    // program data
  } eepec_op_type;

endpackage

// File: hdl/eepec_cells.sv
// nonvolatile array cells and setup cell with program and erase updates
`timescale 1ns/100ps
module eepec_cells
  import eepec_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         op_go,
  input  wire eepec_op_type op,
  input  wire logic [8:0]   rd_index,
  output logic [7:0]        rd_data,
  output logic [7:0]        cell_value
);

  logic [7:0] array_mem [0:ARRAY_BYTES-1]; // array bytes, not reset
  logic [7:0] setup_cell;                  // setup cell, not reset

  // cell update on each issued operation
  always_ff @(posedge clk) begin
    if (op_go) begin
      case (op.kind)
        OP_PROGRAM: begin
          // programming can only pull bits low
          if (op.to_cell) begin
            setup_cell <= setup_cell & op.data;
          end else begin
            array_mem[op.index] <= array_mem[op.index] & op.data;
          end
        end
        OP_ERASE_BYTE: begin
          // single byte back to all ones
          if (op.to_cell) begin
            setup_cell <= ERASED_BYTE;
          end else begin
            array_mem[op.index] <= ERASED_BYTE;
          end
        end
        OP_ERASE_ROW: begin
          // whole 16-byte row holding the index
          if (op.to_cell) begin
            setup_cell <= ERASED_BYTE;
          end else begin
            for (int i = 0; i < ROW_BYTES; i++) begin
              array_mem[(op.index & ~ROW_MASK) | 9'(i)] <= ERASED_BYTE;
            end
          end
        end
        OP_ERASE_BULK: begin
          // whole array, plus the setup cell when aimed at it
          for (int i = 0; i < ARRAY_BYTES; i++) begin
            array_mem[i] <= ERASED_BYTE;
          end
          if (op.to_cell) begin
            setup_cell <= ERASED_BYTE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // read ports, reads never look at protection
  assign rd_data    = array_mem[rd_index];
  assign cell_value = setup_cell;

endmodule

// File: hdl/eepec_ctrl.sv
// eeprom program/erase control: protect and control registers, capture and issue
`timescale 1ns/100ps
module eepec_ctrl
  import eepec_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire eepec_bus_req_type bus_req,
  input  wire logic              single_chip_mode,
  input  wire logic              bootstrap_mode,
  input  wire logic              special_mode,
  output logic [7:0]             bus_rdata,
  output logic                   bus_rdata_valid,
  output logic                   write_capture_enable,
  output logic                   high_voltage_on
);

  // whole state of the controller
  typedef struct packed {
    eepec_protect_type         protect;      // block protect bits
    eepec_program_control_type control;      // program control bits
    logic [6:0]                unlock_count; // cycles since reset
    eepec_setup_type           setup;        // active setup value
    logic                      setup_loaded; // setup copied after reset
    logic                      cap_valid;    // address captured
    logic                      cap_cell;     // capture hit setup cell
    logic [8:0]                cap_index;    // captured array index
    logic [7:0]                cap_data;     // captured data
    logic [7:0]                rdata;        // read data
    logic                      rvalid;       // read data valid
  } eepec_state_type;

  eepec_state_type state;      // registered state
  eepec_state_type next_state; // next state

  eepec_op_type op;           // operation to the cells
  logic         op_go;        // issue strobe
  logic [7:0]   array_rdata;  // array byte at bus address
  logic [7:0]   cell_value;   // stored setup cell
  logic [3:0]   map_page;     // page the array sits in
  logic         map_present;  // array mapped in
  logic         array_hit;    // bus address inside array
  logic         cell_hit;     // bus address is the setup cell
  logic         clear_ok;     // protect bits may be cleared
  logic         op_allowed;   // capture not blocked by protection

  // region bit guarding an array index
  function automatic logic region_protected(
    input logic [8:0] index,
    input logic [3:0] regions
  );
    logic hit;
    hit = regions[3];
    if (index < REGION2_END) begin
      hit = regions[2];
    end
    if (index < REGION1_END) begin
      hit = regions[1];
    end
    if (index < REGION0_END) begin
      hit = regions[0];
    end
    return hit;
  endfunction

  // kind of operation from the control bits
  function automatic eepec_op_kind_type op_kind(
    input eepec_program_control_type ctl
  );
    eepec_op_kind_type kind;
    kind = OP_ERASE_BULK;
    if (!ctl.erase) begin
      kind = OP_PROGRAM;
    end else if (ctl.byte_sel) begin
      kind = OP_ERASE_BYTE;
    end else if (ctl.row_sel) begin
      kind = OP_ERASE_ROW;
    end
    return kind;
  endfunction

  // cell storage
  eepec_cells u_cells (
    .clk        (clk),
    .op_go      (op_go),
    .op         (op),
    .rd_index   (bus_req.addr[8:0]),
    .rd_data    (array_rdata),
    .cell_value (cell_value)
  );

  // array placement from the active setup value and the mode
  always_comb begin
    map_page    = state.setup.array_base_page;
    map_present = state.setup.array_present;
    if (single_chip_mode || bootstrap_mode) begin
      map_page = TOP_PAGE;
    end
    if (single_chip_mode) begin
      map_present = 1'b1;
    end
  end

  // address decode
  assign array_hit = map_present && (bus_req.addr[15:12] == map_page)
                     && (bus_req.addr[11:9] == ARRAY_IN_PAGE);
  assign cell_hit  = (bus_req.addr == ADDR_SETUP_CELL);

  // clearing window: first cycles after reset, or any time in special modes
  assign clear_ok = special_mode || (state.unlock_count != UNLOCK_CYCLES);

  // protection of the captured target
  always_comb begin
    op_allowed = 1'b1;
    if (state.cap_cell && state.protect.setup_cell_protect) begin
      op_allowed = 1'b0;
    end
    if (op_kind(state.control) == OP_ERASE_BULK) begin
      if (state.protect.array_region_protect != 4'h0) begin
        op_allowed = 1'b0;
      end
    end else if (!state.cap_cell) begin
      if (region_protected(state.cap_index, state.protect.array_region_protect)) begin
        op_allowed = 1'b0;
      end
    end
  end

  // next state, operation issue and bus answers
  always_comb begin
    eepec_program_control_type wctl;
    eepec_protect_type         wprot;
    next_state = state;
    wctl       = eepec_program_control_type'(bus_req.wdata);
    wprot      = eepec_protect_type'(bus_req.wdata[4:0]);
    op_go      = 1'b0;
    op.kind    = op_kind(state.control);
    op.to_cell = state.cap_cell;
    op.index   = state.cap_index;
    op.data    = state.cap_data;
    next_state.rvalid = 1'b0;

    // count cycles since reset, saturating
    if (state.unlock_count != UNLOCK_CYCLES) begin
      next_state.unlock_count = state.unlock_count + 7'h01;
    end

    // stored setup value becomes active once, just after reset
    if (!state.setup_loaded) begin
      next_state.setup        = eepec_setup_type'(cell_value);
      next_state.setup_loaded = 1'b1;
    end

    // cpu writes
    if (bus_req.wr) begin
      if (bus_req.addr == ADDR_BLOCK_PROTECT) begin
        // ones always stick, zeros only inside the window
        if (clear_ok) begin
          next_state.protect = wprot;
        end else begin
          next_state.protect = state.protect | wprot;
        end
      end else if (bus_req.addr == ADDR_PROGRAM_CONTROL) begin
        wctl.unused = 1'b0;
        if (wctl.write_capture_enable && wctl.high_voltage_on
            && !state.control.write_capture_enable) begin
          // both at once without a prior latch write: set neither
          wctl.write_capture_enable = 1'b0;
          wctl.high_voltage_on      = 1'b0;
        end else if (!state.control.write_capture_enable) begin
          // voltage bit frozen while not latched
          wctl.high_voltage_on = state.control.high_voltage_on;
        end
        // erase, size and test bits are plain storage
        next_state.control = wctl;
        if (!state.control.write_capture_enable) begin
          // a fresh latch starts with nothing captured
          next_state.cap_valid = 1'b0;
        end
      end else if (state.control.write_capture_enable
                   && !state.control.high_voltage_on
                   && (array_hit || cell_hit)) begin
        // latched: capture address and data instead of a normal write
        // not under voltage, so a running operation is never disturbed
        next_state.cap_valid = 1'b1;
        next_state.cap_cell  = cell_hit;
        next_state.cap_index = bus_req.addr[8:0];
        next_state.cap_data  = bus_req.wdata;
      end
      // writes under voltage, unlatched array or cell writes: ignored
    end

    // voltage falling ends the operation and updates the cells
    if (state.control.high_voltage_on && !next_state.control.high_voltage_on) begin
      if (state.cap_valid && op_allowed) begin
        op_go = 1'b1;
      end
      next_state.cap_valid = 1'b0;
    end

    // dropping the latch forgets any capture
    if (!next_state.control.write_capture_enable) begin
      next_state.cap_valid = 1'b0;
    end

    // cpu reads, answered on the next cycle
    if (bus_req.rd) begin
      next_state.rdata = 8'h00;
      if (bus_req.addr == ADDR_BLOCK_PROTECT) begin
        next_state.rdata  = {3'h0, state.protect};
        next_state.rvalid = 1'b1;
      end else if (bus_req.addr == ADDR_PROGRAM_CONTROL) begin
        next_state.rdata  = state.control;
        next_state.rvalid = 1'b1;
      end else if (cell_hit) begin
        next_state.rdata  = cell_value;
        next_state.rvalid = 1'b1;
      end else if (array_hit) begin
        // plain rom-like read, no protection check
        next_state.rdata  = array_rdata;
        next_state.rvalid = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state.protect      <= eepec_protect_type'(BLOCK_PROTECT_RESET);
      state.control      <= eepec_program_control_type'(8'h00);
      state.unlock_count <= 7'h00;
      state.setup        <= eepec_setup_type'(SETUP_RESET);
      state.setup_loaded <= 1'b0;
      state.cap_valid    <= 1'b0;
      state.cap_cell     <= 1'b0;
      state.cap_index    <= 9'h000;
      state.cap_data     <= 8'h00;
      state.rdata        <= 8'h00;
      state.rvalid       <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign bus_rdata            = state.rdata;
  assign bus_rdata_valid      = state.rvalid;
  assign write_capture_enable = state.control.write_capture_enable;
  // pump runs only when something was captured
  assign high_voltage_on      = state.control.high_voltage_on && state.cap_valid;

endmodule

// File: tb/eepec_properties.sv
// assertions on the ports of the eeprom program/erase control
`timescale 1ns/100ps
module eepec_properties
  import eepec_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire eepec_bus_req_type bus_req,
  input wire logic              single_chip_mode,
  input wire logic              bootstrap_mode,
  input wire logic              special_mode,
  input wire logic [7:0]        bus_rdata,
  input wire logic              bus_rdata_valid,
  input wire logic              write_capture_enable,
  input wire logic              high_voltage_on
);
  // every check runs on clk and stands down while reset is high
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // control register write or plain read taken this cycle
  wire ctl_wr = bus_req.wr && bus_req.addr == ADDR_PROGRAM_CONTROL;
  wire ctl_rd = bus_req.rd && !bus_req.wr && bus_req.addr == ADDR_PROGRAM_CONTROL;

  a_read_answer: assert property (bus_req.rd && !bus_req.wr && (ctl_rd ||
    bus_req.addr == ADDR_BLOCK_PROTECT) |=> bus_rdata_valid)
    else $error("register read not answered");
  a_idle_quiet: assert property (!bus_req.rd |=> !bus_rdata_valid)
    else $error("read data valid without a read");
  a_bit5_zero: assert property (ctl_rd |=> !bus_rdata[5])
    else $error("control bit 5 read as one");
  a_protect_top: assert property (bus_req.rd && bus_req.addr == ADDR_BLOCK_PROTECT
    |=> bus_rdata[7:5] == 3'h0) else $error("protect upper bits not zero");
  a_hv_latched: assert property (high_voltage_on |-> write_capture_enable)
    else $error("voltage on without latch");
  a_pair_refused: assert property (ctl_wr && bus_req.wdata[1:0] == 2'b11 &&
    !write_capture_enable |=> !write_capture_enable && !high_voltage_on)
    else $error("latch and voltage set together");
  a_latch_follows: assert property (ctl_wr && (bus_req.wdata[1:0] != 2'b11 ||
    write_capture_enable) |=> write_capture_enable == $past(bus_req.wdata[1]))
    else $error("latch bit did not take written value");
  a_hv_off_write: assert property (ctl_wr && !bus_req.wdata[0] |=> !high_voltage_on)
    else $error("voltage stayed on after clear");
  a_hv_cause: assert property ($rose(high_voltage_on) |-> $past(ctl_wr))
    else $error("voltage rose without control write");
  a_latch_readback: assert property (ctl_rd |=>
    bus_rdata[1] == $past(write_capture_enable)) else $error("latch readback wrong");
endmodule

bind eepec_ctrl eepec_properties u_props (
  .clk                  (clk),
  .rst                  (rst),
  .bus_req              (bus_req),
  .single_chip_mode     (single_chip_mode),
  .bootstrap_mode       (bootstrap_mode),
  .special_mode         (special_mode),
  .bus_rdata            (bus_rdata),
  .bus_rdata_valid      (bus_rdata_valid),
  .write_capture_enable (write_capture_enable),
  .high_voltage_on      (high_voltage_on)
);

// File: tb/eepec_cpu.sv
// cpu-side model that drives the register bus of the control block
`timescale 1ns/100ps
module eepec_cpu
  import eepec_pkg::*;
(
  input  wire logic         clk,
  input  wire logic [7:0]   bus_rdata,
  input  wire logic         bus_rdata_valid,
  input  wire logic         high_voltage_on,
  output eepec_bus_req_type bus_req
);
  logic hv_seen; // voltage level seen during the last operation wait

  initial begin
    bus_req = '0;
    hv_seen = 1'b0;
  end

  // one bus cycle: drive after an edge, hold over the taking edge, then let go
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    #1;
    bus_req = '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    #1;
    // released lines no longer show the old address or data
    bus_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  // read: returns data and whether an answer came within a few cycles
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    cyc(a, 8'h00, 1'b0);
    for (int k = 0; k < 4 && bus_rdata_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    ok = bus_rdata_valid;
    d  = bus_rdata;
  endtask

  // program or erase; a zero address skips the capture write
  task automatic op(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d);
    cyc(ADDR_PROGRAM_CONTROL, ctl, 1'b1);
    if (a != 16'h0000) cyc(a, d, 1'b1);
    cyc(ADDR_PROGRAM_CONTROL, ctl | 8'h01, 1'b1);
    // stray write while voltage is on must not disturb the operation
    if (a != 16'h0000) cyc(a, 8'h00, 1'b1);
    // voltage time shortened: the block does not time it
    repeat (20) @(posedge clk);
    #1;
    hv_seen = high_voltage_on;
    cyc(ADDR_PROGRAM_CONTROL, 8'h00, 1'b1);
  endtask
endmodule

// File: tb/tb_eeprom_program_erase_control.sv
// self-checking bench for the eeprom program/erase control
`timescale 1ns/100ps
module tb_eeprom_program_erase_control;
  import eepec_pkg::*;
  logic              clk;                  // 100 MHz clock
  logic              rst;                  // async reset
  eepec_bus_req_type bus_req;              // cpu request
  logic [7:0]        bus_rdata;            // read data
  logic              bus_rdata_valid;      // read answer
  logic              write_capture_enable; // latch output
  logic              high_voltage_on;      // voltage output
  logic [7:0]        got;                  // last read value
  logic              ok;                   // last read answered
  int                fail_count;
  int                n_tests;

  // clock generator, well above 1 MHz so the pump clock choice is not needed
  always #5 clk = ~clk;

  eepec_ctrl u_dut (
    .clk                  (clk),
    .rst                  (rst),
    .bus_req              (bus_req),
    .single_chip_mode     (1'b1),
    .bootstrap_mode       (1'b0),
    .special_mode         (1'b0),
    .bus_rdata            (bus_rdata),
    .bus_rdata_valid      (bus_rdata_valid),
    .write_capture_enable (write_capture_enable),
    .high_voltage_on      (high_voltage_on)
  );

  eepec_cpu u_cpu (
    .clk             (clk),
    .bus_rdata       (bus_rdata),
    .bus_rdata_valid (bus_rdata_valid),
    .high_voltage_on (high_voltage_on),
    .bus_req         (bus_req)
  );

  // compare one byte result
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // counts and verdict, then end of run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // read a mapped place and compare; a missing answer ends the run
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    u_cpu.rd(a, got, ok);
    chk("answer", 8'h01, {7'h00, ok});
    if (ok !== 1'b1) summarize();
    chk($sformatf("read %h", a), exp, got);
  endtask

  // hang guard
  initial begin
    #200000;
    fail_count++;
    summarize();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    fail_count = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    rdc(ADDR_BLOCK_PROTECT, 8'h1F);
    // clear every protect bit inside the window after reset
    u_cpu.cyc(ADDR_BLOCK_PROTECT, 8'h00, 1'b1);
    rdc(ADDR_BLOCK_PROTECT, 8'h00);
    // latch and voltage together as the first write: neither sticks
    u_cpu.cyc(ADDR_PROGRAM_CONTROL, 8'h03, 1'b1);
    rdc(ADDR_PROGRAM_CONTROL, 8'h00);
    // bit 5 never reads back, erase bit is plain storage
    u_cpu.cyc(ADDR_PROGRAM_CONTROL, 8'h24, 1'b1);
    rdc(ADDR_PROGRAM_CONTROL, 8'h04);
    u_cpu.cyc(ADDR_PROGRAM_CONTROL, 8'h00, 1'b1);
    // bulk erase gives a known array
    u_cpu.op(8'h06, 16'hFE00, 8'h00);
    chk("voltage seen", 8'h01, {7'h00, u_cpu.hv_seen});
    rdc(16'hFE00, 8'hFF);
    rdc(16'hFFFF, 8'hFF);
    // program one byte, the stray write under voltage is dropped
    u_cpu.op(8'h02, 16'hFE10, 8'hA5);
    rdc(16'hFE10, 8'hA5);
    // no capture: no voltage and no operation
    u_cpu.op(8'h02, 16'h0000, 8'h00);
    chk("voltage idle", 8'h00, {7'h00, u_cpu.hv_seen});
    rdc(16'hFE10, 8'hA5);
    // past the window: ones stick, zeros are refused
    repeat (70) @(posedge clk);
    u_cpu.cyc(ADDR_BLOCK_PROTECT, 8'h01, 1'b1);
    u_cpu.cyc(ADDR_BLOCK_PROTECT, 8'h00, 1'b1);
    rdc(ADDR_BLOCK_PROTECT, 8'h01);
    // region 0 now guarded: program there has no effect, reads still work
    u_cpu.op(8'h02, 16'hFE05, 8'h00);
    rdc(16'hFE05, 8'hFF);
    summarize();
  end
endmodule
